/* rtl/otap_pkg.sv */
/*
 * Shared constants and types of the orientation and tap output block.
 * Assumes a single 100 MHz reference clock and signed 12-bit samples
 * from the measurement chain, one sample per i_sample_valid pulse.
 */
package otap_pkg;

	////////////////////////////////////////////////////////////////////////
	// Clock and timing
	localparam int unsigned OTAP_CLK_KHZ    = 100000;
	localparam int unsigned OTAP_TON_MS     = 30;
	localparam int unsigned OTAP_TON_CYCLES = OTAP_TON_MS * OTAP_CLK_KHZ;

	// Samples of equal class before an orientation is taken as steady
	localparam logic [3:0]  OTAP_STEADY_SAMPLES = 4'h4;
	// Cycles an interrupt line stays high after one event
	localparam logic [4:0]  OTAP_IRQ_HOLD       = 5'h10;

	////////////////////////////////////////////////////////////////////////
	// Angular window: off-axis <= main * tan(3 deg), tan ~ 54 / 1024
	localparam int unsigned OTAP_TAN_SHIFT = 10;
	localparam logic [23:0] OTAP_TAN_NUM   = 24'h000036;

	////////////////////////////////////////////////////////////////////////
	// Sample and configuration carriers
	localparam int unsigned OTAP_SAMPLE_W = 12;
	localparam int unsigned OTAP_GAP_W    = 16;

	typedef struct packed {
		logic signed [OTAP_SAMPLE_W-1:0] x;
		logic signed [OTAP_SAMPLE_W-1:0] y;
		logic signed [OTAP_SAMPLE_W-1:0] z;
	} otap_accel_t;

	typedef struct packed {
		logic                     tap_en;
		logic                     double_en;
		logic [OTAP_SAMPLE_W-1:0] threshold;
		logic [OTAP_GAP_W-1:0]    gap_cycles;
	} otap_tap_cfg_t;

	typedef enum logic [2:0] {
		OTAP_OR_NONE,
		OTAP_OR_PORT_POS,
		OTAP_OR_PORT_NEG,
		OTAP_OR_LAND_POS,
		OTAP_OR_LAND_NEG,
		OTAP_OR_FACE_POS,
		OTAP_OR_FACE_NEG
	} otap_orient_t;

	typedef enum logic [1:0] {
		OTAP_PWR_SLEEP,
		OTAP_PWR_WAKE,
		OTAP_PWR_RUN
	} otap_state_t;

endpackage

/* rtl/otap_sync.sv */
/*
 * Three-stage synchroniser for one level from outside the clock domain.
 * The output follows once the second and third stages agree.
 * Assumes an active-low asynchronous reset; the output resets low.
 */
`timescale 1ns/10ps

module otap_sync
	import otap_pkg::*;
(
	// Clock and reset
	input  wire logic i_ref_clk,
	input  wire logic i_reset_n,
	// Level in and out
	input  wire logic i_level,
	output logic      o_level
);

	logic [2:0] stage_q;
	logic       agree;
	logic       level_d;
	logic       level_q;

	assign agree   = (stage_q[1] == stage_q[2]);
	assign level_d = agree ? stage_q[2] : level_q;
	assign o_level = level_q;

	always_ff @(posedge i_ref_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			stage_q <= 3'h0;
			level_q <= 1'b0;
		end
		else
		begin
			stage_q <= {stage_q[1:0], i_level};
			level_q <= level_d;
		end
	end

endmodule

/* rtl/otap_top.sv */
/*
 * Orientation and tap output logic: classifies steady samples into six
 * orientations, drives the portrait, landscape and polarity lines, and
 * raises single and double tap interrupts; obeys the sleep select pin.
 * Assumes samples arrive on the same clock and the sleep pin is async.
 */
`timescale 1ns/10ps

// Overview of operation
// - The portrait line is high exactly while the reported steady orientation is a portrait one.
// - The landscape line is high exactly while the reported steady orientation is a landscape one.
// - A low sleep select level puts the block in power-down and a high level selects normal operation.
// - The polarity line tells apart the two opposite positions of the portrait, landscape and face classes.
// - In power-down the measurement chain is off and no orientation or tap is detected.
// - After power-down ends, outputs are valid only after a 30 ms turn-on interval.
// - A steady attitude is classed as one of six orientations: two portrait, two landscape, face up, face down.
// - With tap detection enabled, a single tap in any direction raises the tap interrupt line.
// - With double tap enabled, a second tap within the programmed gap raises a distinct double tap line.
// - An orientation is reported only when gravity lies within about 3 degrees of one of the three axes.
module otap_top
	import otap_pkg::*;
#(
	parameter int unsigned TON_CYCLES = OTAP_TON_CYCLES
)
(
	// Clock and reset
	input  wire logic           i_ref_clk,
	input  wire logic           i_reset_n,
	// Power control pin
	input  wire logic           i_sleep_select_n,
	// Measurement chain
	input  wire otap_accel_t    i_sample,
	input  wire logic           i_sample_valid,
	input  wire otap_tap_cfg_t  i_tap_cfg,
	output logic                o_meas_enable,
	// Output lines
	output logic                o_portrait_flag_out,
	output logic                o_landscape_flag_out,
	output logic                o_polarity_flag_out,
	output logic                o_tap_irq,
	output logic                o_double_tap_irq,
	output logic                o_data_valid
);

	////////////////////////////////////////////////////////////////////////
	// Helpers

	function automatic logic [12:0] mag13(input logic signed [12:0] v);
		mag13 = v[12] ? 13'(-v) : 13'(v);
	endfunction

	function automatic logic in_window(input logic [12:0] main_mag,
		input logic [12:0] off_a, input logic [12:0] off_b);
		logic [23:0] lim;
		lim = {11'h0, main_mag} * OTAP_TAN_NUM;
		in_window = (main_mag != 13'h0)
			&& (({11'h0, off_a} << OTAP_TAN_SHIFT) <= lim)
			&& (({11'h0, off_b} << OTAP_TAN_SHIFT) <= lim);
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Sleep select and power state

	logic        awake;
	otap_state_t state_q;
	otap_state_t state_d;
	logic [31:0] ton_cnt_q;
	logic [31:0] ton_cnt_d;

	otap_sync u_sleep_sync (
		.i_ref_clk (i_ref_clk),
		.i_reset_n (i_reset_n),
		.i_level   (i_sleep_select_n),
		.o_level   (awake)
	);

	always_comb
	begin
		state_d   = state_q;
		ton_cnt_d = ton_cnt_q;
		case (state_q)
			OTAP_PWR_SLEEP:
			begin
				ton_cnt_d = 32'h0;
				if (awake)
					state_d = OTAP_PWR_WAKE;
			end
			OTAP_PWR_WAKE:
			begin
				ton_cnt_d = ton_cnt_q + 32'h1;
				if (!awake)
					state_d = OTAP_PWR_SLEEP;
				else if (ton_cnt_q >= 32'(TON_CYCLES - 1))
					state_d = OTAP_PWR_RUN;
			end
			OTAP_PWR_RUN:
			begin
				if (!awake)
					state_d = OTAP_PWR_SLEEP;
			end
			default:
				state_d = OTAP_PWR_SLEEP;
		endcase
	end

	wire chain_on = (state_d != OTAP_PWR_SLEEP);
	wire accept   = i_sample_valid && (state_q == OTAP_PWR_RUN) && awake;

	////////////////////////////////////////////////////////////////////////
	// Orientation classification

	wire logic signed [12:0] sx = 13'(i_sample.x);
	wire logic signed [12:0] sy = 13'(i_sample.y);
	wire logic signed [12:0] sz = 13'(i_sample.z);
	wire logic [12:0]        ax = mag13(sx);
	wire logic [12:0]        ay = mag13(sy);
	wire logic [12:0]        az = mag13(sz);
	wire logic               win_face = in_window(az, ax, ay);
	wire logic               win_port = in_window(ay, ax, az);
	wire logic               win_land = in_window(ax, ay, az);

	otap_orient_t cand;
	always_comb
	begin
		cand = OTAP_OR_NONE;
		if (win_face)
			cand = sz[12] ? OTAP_OR_FACE_NEG : OTAP_OR_FACE_POS;
		else if (win_port)
			cand = sy[12] ? OTAP_OR_PORT_NEG : OTAP_OR_PORT_POS;
		else if (win_land)
			cand = sx[12] ? OTAP_OR_LAND_NEG : OTAP_OR_LAND_POS;
	end

	otap_orient_t last_q;
	logic [3:0]   steady_q;
	logic [3:0]   steady_d;
	wire          same     = (cand == last_q) && (cand != OTAP_OR_NONE);
	assign steady_d        = (cand == OTAP_OR_NONE) ? 4'h0
		: !same ? 4'h1
		: (steady_q == OTAP_STEADY_SAMPLES) ? steady_q : steady_q + 4'h1;
	wire          commit   = accept && (steady_d == OTAP_STEADY_SAMPLES);

	wire port_d = (cand == OTAP_OR_PORT_POS) || (cand == OTAP_OR_PORT_NEG);
	wire land_d = (cand == OTAP_OR_LAND_POS) || (cand == OTAP_OR_LAND_NEG);
	wire pol_d  = (cand == OTAP_OR_PORT_POS) || (cand == OTAP_OR_LAND_POS)
		|| (cand == OTAP_OR_FACE_POS);

	////////////////////////////////////////////////////////////////////////
	// Tap detection

	otap_accel_t  prev_q;
	logic         prev_ok_q;
	logic         over_q;
	logic [15:0]  gap_q;
	logic [15:0]  gap_d;
	wire logic [12:0] dx = mag13(sx - 13'(prev_q.x));
	wire logic [12:0] dy = mag13(sy - 13'(prev_q.y));
	wire logic [12:0] dz = mag13(sz - 13'(prev_q.z));
	wire logic [12:0] thr = {1'b0, i_tap_cfg.threshold};
	wire over    = prev_ok_q && ((dx > thr) || (dy > thr) || (dz > thr));
	wire tap_hit = accept && i_tap_cfg.tap_en && over && !over_q;
	wire dbl_hit = tap_hit && i_tap_cfg.double_en && (gap_q != 16'h0);
	wire one_hit = tap_hit && !dbl_hit;

	assign gap_d = !chain_on ? 16'h0
		: dbl_hit ? 16'h0
		: one_hit ? i_tap_cfg.gap_cycles
		: (gap_q != 16'h0) ? gap_q - 16'h1 : 16'h0;

	logic [4:0] tap_hold_q;
	logic [4:0] dbl_hold_q;
	wire  [4:0] tap_hold_d = !chain_on ? 5'h0 : one_hit ? OTAP_IRQ_HOLD
		: (tap_hold_q != 5'h0) ? tap_hold_q - 5'h1 : 5'h0;
	wire  [4:0] dbl_hold_d = !chain_on ? 5'h0 : dbl_hit ? OTAP_IRQ_HOLD
		: (dbl_hold_q != 5'h0) ? dbl_hold_q - 5'h1 : 5'h0;

	////////////////////////////////////////////////////////////////////////
	// Registers

	always_ff @(posedge i_ref_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			state_q   <= OTAP_PWR_SLEEP;
			ton_cnt_q <= 32'h0;
		end
		else
		begin
			state_q   <= state_d;
			ton_cnt_q <= ton_cnt_d;
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			last_q   <= OTAP_OR_NONE;
			steady_q <= 4'h0;
		end
		else if (!chain_on)
		begin
			last_q   <= OTAP_OR_NONE;
			steady_q <= 4'h0;
		end
		else if (accept)
		begin
			last_q   <= cand;
			steady_q <= steady_d;
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			o_portrait_flag_out  <= 1'b0;
			o_landscape_flag_out <= 1'b0;
			o_polarity_flag_out  <= 1'b0;
		end
		else if (commit)
		begin
			o_portrait_flag_out  <= port_d;
			o_landscape_flag_out <= land_d;
			o_polarity_flag_out  <= pol_d;
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			prev_q    <= '0;
			prev_ok_q <= 1'b0;
			over_q    <= 1'b0;
		end
		else if (!chain_on)
		begin
			prev_ok_q <= 1'b0;
			over_q    <= 1'b0;
		end
		else if (accept)
		begin
			prev_q    <= i_sample;
			prev_ok_q <= 1'b1;
			over_q    <= over;
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			gap_q            <= 16'h0;
			tap_hold_q       <= 5'h0;
			dbl_hold_q       <= 5'h0;
			o_tap_irq        <= 1'b0;
			o_double_tap_irq <= 1'b0;
			o_meas_enable    <= 1'b0;
			o_data_valid     <= 1'b0;
		end
		else
		begin
			gap_q            <= gap_d;
			tap_hold_q       <= tap_hold_d;
			dbl_hold_q       <= dbl_hold_d;
			o_tap_irq        <= (tap_hold_d != 5'h0);
			o_double_tap_irq <= (dbl_hold_d != 5'h0);
			o_meas_enable    <= chain_on;
			o_data_valid     <= (state_d == OTAP_PWR_RUN);
		end
	end

endmodule

/* tb/otap_host_model.sv */
/*
 * Host side model: drives the sleep select pin and latches the lines.
 * Assumes the bench gives the wanted power state on i_wake.
 */
`timescale 1ns/10ps

module otap_host_model
(
	// Clock and command
	input  wire logic       i_ref_clk,
	input  wire logic       i_wake,
	// Lines from the device
	input  wire logic       i_data_valid,
	input  wire logic [2:0] i_flags,
	// Pin and host view
	output logic            o_sleep_select_n,
	output logic [2:0]      o_seen_flags
);
	initial o_sleep_select_n = 1'b0;
	initial o_seen_flags = 3'h0;
	always @(negedge i_ref_clk)
		o_sleep_select_n <= i_wake;
	// Lines are taken only once valid
	always @(posedge i_ref_clk)
		if (i_data_valid)
			o_seen_flags <= i_flags;
endmodule

/* tb/otap_assertions.sv */
/*
 * Checker of the orientation and tap output lines.
 * Assumes it is bound to otap_top from the testbench top file.
 */
`timescale 1ns/10ps

module otap_assertions
	import otap_pkg::*;
#(
	parameter int unsigned TON_CYCLES = OTAP_TON_CYCLES
)
(
	// Clock and reset
	input wire logic          i_ref_clk,
	input wire logic          i_reset_n,
	// Watched ports
	input wire logic          i_sleep_select_n,
	input wire otap_accel_t   i_sample,
	input wire logic          i_sample_valid,
	input wire otap_tap_cfg_t i_tap_cfg,
	input wire logic          o_meas_enable,
	input wire logic          o_portrait_flag_out,
	input wire logic          o_landscape_flag_out,
	input wire logic          o_polarity_flag_out,
	input wire logic          o_tap_irq,
	input wire logic          o_double_tap_irq,
	input wire logic          o_data_valid
);
	logic [31:0] wait_q;
	wire  [2:0]  flags = {o_portrait_flag_out, o_landscape_flag_out, o_polarity_flag_out};
	// Cycles spent powered but not yet valid
	always_ff @(posedge i_ref_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
			wait_q <= 32'h0;
		else if (!o_meas_enable)
			wait_q <= 32'h0;
		else if (!o_data_valid)
			wait_q <= wait_q + 32'h1;
	end
	////////////////////////////////////////////////////////////////////////
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (!i_reset_n);
	sequence s_asleep2;
		!o_meas_enable ##1 !o_meas_enable;
	endsequence
	sequence s_pin_high;
		i_sleep_select_n [*8];
	endsequence
	a_flags_exclusive: assert property (!(o_portrait_flag_out && o_landscape_flag_out))
		else $error("portrait and landscape both high");
	a_valid_needs_power: assert property (o_data_valid |-> o_meas_enable)
		else $error("valid without power");
	a_valid_after_ton: assert property ($rose(o_data_valid) |-> wait_q == TON_CYCLES)
		else $error("valid rose at wrong time");
	a_sleep_powers_off: assert property (!i_sleep_select_n [*8] |-> !o_meas_enable && !o_data_valid)
		else $error("still powered in sleep");
	a_wake_powers_on: assert property (s_pin_high |-> o_meas_enable)
		else $error("not powered after wake");
	a_tap_needs_power: assert property ($rose(o_tap_irq) |-> o_meas_enable && i_tap_cfg.tap_en)
		else $error("tap without power or enable");
	a_tap_stands: assert property ($rose(o_tap_irq) |-> o_tap_irq [*8])
		else $error("tap line too short");
	a_double_needs_en: assert property ($rose(o_double_tap_irq) |-> i_tap_cfg.double_en)
		else $error("double tap while disabled");
	a_held_asleep: assert property (s_asleep2 |-> $stable(flags))
		else $error("flags moved in sleep");
	a_flags_need_sample: assert property (!$stable(flags) |-> $past(i_sample_valid))
		else $error("flags moved without sample");
endmodule

/* tb/testbench.sv */
/*
 * Self-checking bench of otap_top with a host model on the pins.
 * Assumes a shortened turn-on count of 50 cycles.
 */
`timescale 1ns/10ps

module testbench
	import otap_pkg::*;
;
	logic          i_ref_clk = 1'b0, i_reset_n = 1'b0, wake = 1'b0, i_sample_valid = 1'b0;
	otap_accel_t   i_sample = '0;
	otap_tap_cfg_t i_tap_cfg = '0;
	logic          i_sleep_select_n, o_meas_enable, o_tap_irq, o_double_tap_irq, o_data_valid;
	logic          o_portrait_flag_out, o_landscape_flag_out, o_polarity_flag_out;
	logic [2:0]    seen;
	int            mismatches = 0, tests_run = 0;
	wire  [2:0]    flags = {o_portrait_flag_out, o_landscape_flag_out, o_polarity_flag_out};

	otap_top #(.TON_CYCLES(50)) dut (.i_ref_clk, .i_reset_n, .i_sleep_select_n, .i_sample,
		.i_sample_valid, .i_tap_cfg, .o_meas_enable, .o_portrait_flag_out, .o_landscape_flag_out,
		.o_polarity_flag_out, .o_tap_irq, .o_double_tap_irq, .o_data_valid);
	otap_host_model host (.i_ref_clk, .i_wake(wake), .i_data_valid(o_data_valid), .i_flags(flags),
		.o_sleep_select_n(i_sleep_select_n), .o_seen_flags(seen));

	initial forever #5 i_ref_clk = ~i_ref_clk;
	////////////////////////////////////////////////////////////////////////
	task automatic check(string what, logic [15:0] got, logic [15:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic bound(int n, int lim);
		if (n >= lim)
		begin
			mismatches++;
			$display("wrong value wait expected done seen timeout");
			report_and_stop();
		end
	endtask
	task automatic send(logic signed [11:0] x, logic signed [11:0] y, logic signed [11:0] z);
		@(negedge i_ref_clk);
		i_sample = '{x, y, z};
		i_sample_valid = 1'b1;
		@(negedge i_ref_clk);
		i_sample_valid = 1'b0;
	endtask
	task automatic wake_up;
		int n;
		wake = 1'b1;
		for (n = 0; n < 20 && o_meas_enable !== 1'b1; n++) @(negedge i_ref_clk);
		bound(n, 20);
		for (n = 0; n < 200 && o_data_valid !== 1'b1; n++) @(negedge i_ref_clk);
		bound(n, 200);
		check("turn on", 16'(n), 16'h0032);
	endtask
	////////////////////////////////////////////////////////////////////////
	task automatic t_orient;
		logic signed [11:0] v [6][3] = '{'{0, 1000, 0}, '{0, -1000, 0}, '{1000, 0, 0},
			'{-1000, 0, 0}, '{0, 0, 1000}, '{0, 0, -1000}};
		logic [2:0] e [6] = '{3'h5, 3'h4, 3'h3, 3'h2, 3'h1, 3'h0};
		for (int i = 0; i < 6; i++)
		begin
			repeat (4) send(v[i][0], v[i][1], v[i][2]);
			@(negedge i_ref_clk);
			check("flags", 16'(flags), 16'(e[i]));
			check("host flags", 16'(seen), 16'(e[i]));
		end
		check("tap off", 16'(o_tap_irq), 16'h0);
		$display("orientation test done");
	endtask
	task automatic t_window;
		// Known nonzero reading, so a held value is told from a cleared one
		repeat (4) send(-1000, 0, 0);
		check("land neg", 16'(flags), 16'h2);
		repeat (4) send(53, 1000, 0);
		check("outside", 16'(flags), 16'h2);
		repeat (3) send(52, 1000, 0);
		check("unsteady", 16'(flags), 16'h2);
		send(52, 1000, 0);
		check("inside", 16'(flags), 16'h5);
		$display("window test done");
	endtask
	task automatic t_tap;
		int n;
		// Settle the baseline with taps off, so the jump from the last reading is no tap
		send(0, 0, 0);
		i_tap_cfg = '{1'b1, 1'b1, 12'h064, 16'h03e8};
		send(0, 0, 0);
		check("quiet", 16'(o_tap_irq), 16'h0);
		send(500, 0, 0);
		for (n = 0; n < 4 && o_tap_irq !== 1'b1; n++) @(negedge i_ref_clk);
		bound(n, 4);
		check("single", 16'(o_tap_irq), 16'h1);
		check("no double", 16'(o_double_tap_irq), 16'h0);
		send(500, 0, 0);
		send(0, 0, 0);
		for (n = 0; n < 4 && o_double_tap_irq !== 1'b1; n++) @(negedge i_ref_clk);
		bound(n, 4);
		check("double", 16'(o_double_tap_irq), 16'h1);
		repeat (30) @(negedge i_ref_clk);
		i_tap_cfg.double_en = 1'b0;
		// Two rising crossings within the gap, both single with double off
		send(0, 0, 0);
		send(500, 0, 0);
		send(500, 0, 0);
		send(0, 0, 0);
		repeat (3) @(negedge i_ref_clk);
		check("taps single", 16'({o_tap_irq, o_double_tap_irq}), 16'h2);
		repeat (20) @(negedge i_ref_clk);
		check("tap ends", 16'(o_tap_irq), 16'h0);
		$display("tap test done");
	endtask
	task automatic t_sleep;
		int n;
		logic [2:0] f;
		f = flags;
		wake = 1'b0;
		for (n = 0; n < 20 && o_meas_enable !== 1'b0; n++) @(negedge i_ref_clk);
		bound(n, 20);
		check("valid off", 16'(o_data_valid), 16'h0);
		repeat (4) send(0, -1000, 0);
		send(0, 0, 0);
		send(500, 0, 0);
		check("held", 16'(flags), 16'(f));
		check("no tap", 16'(o_tap_irq), 16'h0);
		wake_up();
		$display("sleep test done");
	endtask

	initial
	begin
		repeat (16) @(negedge i_ref_clk);
		i_reset_n = 1'b1;
		check("asleep", 16'(o_meas_enable), 16'h0);
		wake_up();
		t_orient();
		t_window();
		t_tap();
		t_sleep();
		report_and_stop();
	end
endmodule

bind otap_top otap_assertions #(.TON_CYCLES(TON_CYCLES)) u_chk (.i_ref_clk, .i_reset_n,
	.i_sleep_select_n, .i_sample, .i_sample_valid, .i_tap_cfg, .o_meas_enable,
	.o_portrait_flag_out, .o_landscape_flag_out, .o_polarity_flag_out, .o_tap_irq,
	.o_double_tap_irq, .o_data_valid);
